/* design/vtr_core.sv */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) After reset the program counter is loaded with 000H.
// (R2) Finished serial word, enabled, stack not full: branch to 004H.
// (R3) Timer overflow, enabled, stack not full: branch to 008H.
// (R4) Falling edge on external interrupt, enabled, stack free: branch 00CH.
// (R5) Table read writes low byte to named location, upper bits to 08H.
// (R6) Current-page read, option off: page from PC bits, low from pointer.
// (R7) Option on: current-page read takes page from high pointer bits 3..0.
// (R8) Last-page read forces page bits to ones, range F00H to FFFH.
// (R9) Table high byte bits without program-word bits read zero.
// (R10) Table high byte is read-only; only table reads update it.
// (R11) Pointer low 07H and high 1FH are read/write; high ignored if off.
// (R12) High pointer option defaults to disabled.
// (R13) Current-page read stays inside the 256-word page.
// (R14) Every table read takes two instruction cycles.
// (R15) Software guards main-routine table reads against interrupt reuse.
// (R16) Data memory is 8 bits wide, SFRs from 00H then general purpose.
// (R17) Bit set and clear instructions change one general purpose bit only.
// (R18) With stack full a request stays pending until stack frees.
// (R19) Program memory is 4K by 15, addressed by 12 bits.
// (R20) Simultaneous pending requests are served lowest vector first.
module vtr_core
  import vtr_pkg::*;
#(
  parameter bit HIGH_PTR_EN = 1'b0,     // [R12]
  parameter int DEPTH       = DM_DEPTH
) (
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire vtr_dm_req_type  dm_req,
  output logic [DW-1:0]        dm_rdata_q,
  input  wire logic            tbl_start,
  input  wire vtr_tbl_req_type tbl_req,
  output logic                 tbl_busy_q,
  output logic                 tbl_done_q,
  input  wire logic [3:0]      program_counter_page_bits,
  output logic [PC_W-1:0]      pm_addr_q,
  output logic                 pm_rd_q,
  input  wire logic [PW_W-1:0] pm_data,
  input  wire logic            serial_done,
  input  wire logic            timer_ovf,
  input  wire logic            ext_int_n,
  input  wire logic [2:0]      int_enable,
  input  wire logic            stack_full,
  output logic                 pc_load_q,
  output logic [PC_W-1:0]      pc_addr_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the read path and the write path.

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (int'(a) >= GP_START) && (int'(a) < DEPTH);
  endfunction

  function automatic int gp_index(input logic [7:0] a);
    gp_index = int'(a) - GP_START;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [DW-1:0]   tbl_ptr_low_q;
  logic [DW-1:0]   tbl_ptr_high_q;
  logic [DW-1:0]   tbl_high_byte_q;
  logic [DW-1:0]   gp_mem_q [DEPTH-GP_START];
  vtr_state_type   state_q;
  vtr_tbl_req_type req_q;
  logic            ext_prev_q;
  logic            boot_q;
  logic [2:0]      pend_q;
  logic [PC_W-1:0] tbl_addr_d;
  logic            ext_fall;
  logic            dm_gp_wr;
  logic            tbl_wr;
  logic            int_go;
  logic [2:0]      serve;
  localparam int   GP_AW = $clog2(DEPTH - GP_START);

  ////////////////////////////////////////////////////////////////////////////
  // Table address formation.

  always_comb begin
    tbl_addr_d[7:0] = tbl_ptr_low_q;                      // [R13]
    if (tbl_req.last_page) begin
      tbl_addr_d[11:8] = LAST_PAGE;                       // [R8]
    end else if (HIGH_PTR_EN) begin
      tbl_addr_d[11:8] = tbl_ptr_high_q[3:0];             // [R7]
    end else begin
      tbl_addr_d[11:8] = program_counter_page_bits;       // [R6] [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table-read sequencer: issue cycle, then fetch cycle.

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      req_q      <= '0;
      pm_addr_q  <= VEC_RESET;
      pm_rd_q    <= 1'b0;
      tbl_busy_q <= 1'b0;
      tbl_done_q <= 1'b0;
    end else begin
      tbl_done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (tbl_start) begin
            state_q    <= ST_FETCH;                       // [R14]
            req_q      <= tbl_req;
            pm_addr_q  <= tbl_addr_d;                     // [R19]
            pm_rd_q    <= 1'b1;
            tbl_busy_q <= 1'b1;
          end
        end
        ST_FETCH: begin
          state_q    <= ST_IDLE;
          pm_rd_q    <= 1'b0;
          tbl_busy_q <= 1'b0;
          tbl_done_q <= 1'b1;                             // [R14]
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign tbl_wr = (state_q == ST_FETCH);

  // The high byte only changes on a table read; core writes to it are dropped.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tbl_high_byte_q <= RESET_BYTE;
    end else if (tbl_wr) begin
      tbl_high_byte_q <= {1'b0, pm_data[PW_W-1:DW]};      // [R5] [R9] [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer registers.

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tbl_ptr_low_q  <= RESET_BYTE;
      tbl_ptr_high_q <= RESET_BYTE;
    end else if (dm_req.wr && !tbl_wr) begin
      if (dm_req.addr == ADDR_TBL_PTR_LOW) begin
        tbl_ptr_low_q <= dm_req.wdata;                    // [R11]
      end
      if (dm_req.addr == ADDR_TBL_PTR_HIGH) begin
        tbl_ptr_high_q <= dm_req.wdata;                   // [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General purpose memory. The table-read write port wins over a core
  // access in the same cycle, because dm_gp_wr is gated off by tbl_wr.

  assign dm_gp_wr = !tbl_wr && is_gp(dm_req.addr);

  for (genvar i = 0; i < DEPTH - GP_START; i++) begin : g_mem
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        gp_mem_q[i] <= RESET_BYTE;
      end else if (tbl_wr && is_gp(req_q.dest)
                   && gp_index(req_q.dest) == i) begin
        gp_mem_q[i] <= pm_data[DW-1:0];                   // [R5]
      end else if (dm_gp_wr && gp_index(dm_req.addr) == i) begin
        if (dm_req.wr) begin
          gp_mem_q[i] <= dm_req.wdata;                    // [R16]
        end else if (dm_req.set) begin
          gp_mem_q[i][dm_req.bit_sel] <= 1'b1;            // [R17]
        end else if (dm_req.clr) begin
          gp_mem_q[i][dm_req.bit_sel] <= 1'b0;            // [R17]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: answered one cycle after the request; unused SFRs read 00H.

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dm_rdata_q <= RESET_BYTE;
    end else if (dm_req.rd) begin
      if (dm_req.addr == ADDR_TBL_PTR_LOW) begin
        dm_rdata_q <= tbl_ptr_low_q;
      end else if (dm_req.addr == ADDR_TBL_HIGH) begin
        dm_rdata_q <= tbl_high_byte_q;
      end else if (dm_req.addr == ADDR_TBL_PTR_HIGH) begin
        dm_rdata_q <= tbl_ptr_high_q;
      end else if (is_gp(dm_req.addr)) begin
        dm_rdata_q <= gp_mem_q[GP_AW'(gp_index(dm_req.addr))]; // [R16]
      end else begin
        dm_rdata_q <= RESET_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests. Bit 0 serial, bit 1 timer, bit 2 external.

  assign ext_fall = ext_prev_q && !ext_int_n;             // [R4]
  assign int_go   = !stack_full && !tbl_busy_q && !tbl_start && !boot_q;

  always_comb begin
    serve = '0;
    if (int_go) begin
      if (pend_q[0] && int_enable[0]) begin
        serve[0] = 1'b1;                                  // [R20]
      end else if (pend_q[1] && int_enable[1]) begin
        serve[1] = 1'b1;
      end else if (pend_q[2] && int_enable[2]) begin
        serve[2] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= ext_int_n;
    end
  end

  // A new event in the serving cycle keeps its flag set.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~serve)
              | {ext_fall, timer_ovf, serial_done};       // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter load requests.

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      boot_q    <= 1'b1;
      pc_load_q <= 1'b0;
      pc_addr_q <= VEC_RESET;
    end else begin
      boot_q    <= 1'b0;
      pc_load_q <= boot_q || (serve != '0);
      if (boot_q) begin
        pc_addr_q <= VEC_RESET;                           // [R1]
      end else if (serve[0]) begin
        pc_addr_q <= VEC_SERIAL;                          // [R2]
      end else if (serve[1]) begin
        pc_addr_q <= VEC_TIMER;                           // [R3]
      end else if (serve[2]) begin
        pc_addr_q <= VEC_EXT;                             // [R4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence tbl_issue_s;
    state_q == ST_IDLE && tbl_start;
  endsequence

  sequence tbl_finish_s;
    tbl_busy_q && pm_rd_q ##1 tbl_done_q && !tbl_busy_q;
  endsequence

  reset_vector_a: assert property ( // [R1]
    @(posedge sys_clk) $rose(resetn) |=> pc_load_q && pc_addr_q == VEC_RESET)
    else $error("reset did not load vector zero");

  two_cycle_read_a: assert property ( // [R14]
    @(posedge sys_clk) disable iff (!resetn)
    tbl_issue_s |=> tbl_finish_s)
    else $error("table read not two cycles");

  last_page_a: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!resetn)
    tbl_issue_s and tbl_req.last_page |=>
      pm_addr_q == {LAST_PAGE, $past(tbl_ptr_low_q)})
    else $error("last page address wrong");

  current_page_a: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!resetn)
    tbl_issue_s and !tbl_req.last_page and !HIGH_PTR_EN |=>
      pm_addr_q == {$past(program_counter_page_bits), $past(tbl_ptr_low_q)})
    else $error("current page address wrong");

  high_byte_load_a: assert property ( // [R9]
    @(posedge sys_clk) disable iff (!resetn)
    tbl_wr |=> tbl_high_byte_q == {1'b0, $past(pm_data[PW_W-1:DW])})
    else $error("table high byte not loaded");

  high_byte_ro_a: assert property ( // [R10]
    @(posedge sys_clk) disable iff (!resetn)
    !tbl_wr |=> $stable(tbl_high_byte_q))
    else $error("table high byte changed outside table read");

  serial_vector_a: assert property ( // [R2]
    @(posedge sys_clk) disable iff (!resetn)
    serve[0] |=> pc_load_q && pc_addr_q == VEC_SERIAL)
    else $error("serial vector wrong");

  priority_a: assert property ( // [R20]
    @(posedge sys_clk) disable iff (!resetn)
    int_go && pend_q[0] && int_enable[0] && pend_q[1] |=>
      pc_addr_q == VEC_SERIAL)
    else $error("priority order broken");

  stack_hold_a: assert property ( // [R18]
    @(posedge sys_clk) disable iff (!resetn)
    stack_full && !boot_q |=> !pc_load_q)
    else $error("interrupt served with stack full");

  ext_edge_a: assert property ( // [R4]
    @(posedge sys_clk) disable iff (!resetn)
    $fell(ext_int_n) |=> pend_q[2])
    else $error("falling edge not latched");

  high_page_a: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!resetn)
    tbl_issue_s and !tbl_req.last_page and HIGH_PTR_EN |=>
      pm_addr_q == {$past(tbl_ptr_high_q[3:0]), $past(tbl_ptr_low_q)})
    else $error("high pointer page wrong");

  fetch_page_a: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!resetn)
    state_q == ST_FETCH && req_q.last_page |-> pm_addr_q[11:8] == LAST_PAGE)
    else $error("last page not held in fetch");

  fetch_once_a: assert property ( // [R14]
    @(posedge sys_clk) disable iff (!resetn)
    state_q == ST_FETCH |=> state_q == ST_IDLE && !pm_rd_q)
    else $error("table read fetched twice");

endmodule // vtr_core

/* include/vtr_pkg.sv */
package vtr_pkg;

  localparam int PC_W = 12;
  localparam int PW_W = 15;
  localparam int DW   = 8;

  localparam logic [11:0] VEC_RESET  = 12'h000;
  localparam logic [11:0] VEC_SERIAL = 12'h004;
  localparam logic [11:0] VEC_TIMER  = 12'h008;
  localparam logic [11:0] VEC_EXT    = 12'h00c;

  localparam logic [7:0] ADDR_TBL_PTR_LOW  = 8'h07;
  localparam logic [7:0] ADDR_TBL_HIGH     = 8'h08;
  localparam logic [7:0] ADDR_TBL_PTR_HIGH = 8'h1f;

  localparam logic [3:0] LAST_PAGE  = 4'hf;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int         GP_START   = 32;
  localparam int         DM_DEPTH   = 128;
  localparam int         TBL_CYCLES = 2;

  typedef enum {ST_IDLE, ST_FETCH} vtr_state_type;

  // Table-read instruction as issued by the core.
  typedef struct packed {
    logic       last_page;
    logic [7:0] dest;
  } vtr_tbl_req_type;

  // Data-memory access as issued by the core.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       set;
    logic       clr;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vtr_dm_req_type;

endpackage

/* testbench/vtr_core_tb_top.sv */
`timescale 1ns/1ns
module vtr_core_tb_top
  import vtr_pkg::*;
;
  typedef struct packed {
    logic        last;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [3:0]  page;
    logic [11:0] exp;
    logic [11:0] hp;
  } vtr_row_type;

  logic            sys_clk     = 1'b0;
  logic            resetn      = 1'b0;
  vtr_dm_req_type  dm_req      = '0;
  logic [DW-1:0]   dm_rdata_q;
  logic            tbl_start   = 1'b0;
  vtr_tbl_req_type tbl_req     = '0;
  logic            tbl_busy_q;
  logic            tbl_done_q;
  logic [3:0]      pc_page     = 4'h0;
  logic [PC_W-1:0] pm_addr_q;
  logic [PC_W-1:0] hp_pm_addr;
  logic            pm_rd_q;
  logic [PW_W-1:0] pm_data;
  logic            serial_done = 1'b0;
  logic            timer_ovf   = 1'b0;
  logic            ext_int_n   = 1'b1;
  logic [2:0]      int_enable  = 3'h0;
  logic            stack_full  = 1'b0;
  logic            pc_load_q;
  logic [PC_W-1:0] pc_addr_q;
  logic [7:0]      rd_v;
  int              mismatches  = 0;
  int              tests_run   = 0;

  // Pointer high differs from the page bits except in the last row, so a leak of it shows up.
  vtr_row_type rows [4] = '{
    '{1'b0, 8'h34, 8'h0a, 4'h3, 12'h334, 12'ha34},
    '{1'b0, 8'hff, 8'h05, 4'h7, 12'h7ff, 12'h5ff},
    '{1'b1, 8'h06, 8'h02, 4'h3, 12'hf06, 12'hf06},
    '{1'b1, 8'h00, 8'h00, 4'h0, 12'hf00, 12'hf00}
  };

  always #5 sys_clk = ~sys_clk;

  // The word is 101 above its 12 address bits; outside a fetch it is inverted.
  assign pm_data = pm_rd_q ? {3'h5, pm_addr_q} : ~{3'h5, pm_addr_q};

  vtr_core dut (
    .sys_clk                   (sys_clk),
    .resetn                    (resetn),
    .dm_req                    (dm_req),
    .dm_rdata_q                (dm_rdata_q),
    .tbl_start                 (tbl_start),
    .tbl_req                   (tbl_req),
    .tbl_busy_q                (tbl_busy_q),
    .tbl_done_q                (tbl_done_q),
    .program_counter_page_bits (pc_page),
    .pm_addr_q                 (pm_addr_q),
    .pm_rd_q                   (pm_rd_q),
    .pm_data                   (pm_data),
    .serial_done               (serial_done),
    .timer_ovf                 (timer_ovf),
    .ext_int_n                 (ext_int_n),
    .int_enable                (int_enable),
    .stack_full                (stack_full),
    .pc_load_q                 (pc_load_q),
    .pc_addr_q                 (pc_addr_q)
  );

  // Second copy with the high pointer option on; only its address is used.
  vtr_core #(
    .HIGH_PTR_EN (1'b1)
  ) dut_hp (
    .sys_clk                   (sys_clk),
    .resetn                    (resetn),
    .dm_req                    (dm_req),
    .dm_rdata_q                (),
    .tbl_start                 (tbl_start),
    .tbl_req                   (tbl_req),
    .tbl_busy_q                (),
    .tbl_done_q                (),
    .program_counter_page_bits (pc_page),
    .pm_addr_q                 (hp_pm_addr),
    .pm_rd_q                   (),
    .pm_data                   (pm_data),
    .serial_done               (serial_done),
    .timer_ovf                 (timer_ovf),
    .ext_int_n                 (ext_int_n),
    .int_enable                (int_enable),
    .stack_full                (stack_full),
    .pc_load_q                 (),
    .pc_addr_q                 ()
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Op is wr, rd, set, clr; the strobe stands for exactly one edge.
  task automatic dm(input logic [3:0] op, input logic [2:0] b,
                    input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    dm_req = '{op[3], op[2], op[1], op[0], b, a, d};
    @(negedge sys_clk);
    dm_req = '0;
    rd_v = dm_rdata_q;
  endtask

  task automatic tbl(input logic last, input logic [11:0] exp,
                     input logic [11:0] exp_hp);
    @(negedge sys_clk);
    tbl_req = '{last, 8'h40};
    tbl_start = 1'b1;
    @(negedge sys_clk);
    tbl_start = 1'b0;
    chk(tbl_busy_q, 12'h1);
    chk(pm_rd_q, 12'h1);
    chk(pm_addr_q, exp);
    chk(hp_pm_addr, exp_hp);
    repeat (TBL_CYCLES - 1) @(negedge sys_clk);
    chk(tbl_done_q, 12'h1);
    dm(4'h4, 3'h0, 8'h40, 8'h00);
    chk(rd_v, exp[7:0]);
    dm(4'h4, 3'h0, ADDR_TBL_HIGH, 8'h00);
    chk(rd_v, {4'h5, exp[11:8]});
  endtask

  task automatic wait_load(input logic [11:0] exp);
    int i;
    for (i = 0; i < 20 && pc_load_q !== 1'b1; i++) @(negedge sys_clk);
    if (pc_load_q !== 1'b1) begin
      mismatches++;
      summarize();
    end else begin
      chk(pc_addr_q, exp);
      @(negedge sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge sys_clk);
    chk(pc_load_q, 12'h0);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk(pc_load_q, 12'h1);
    chk(pc_addr_q, VEC_RESET);
    // Interrupts stay disabled while tables are read, so no handler can
    // overwrite the high byte before it has been read back.
    foreach (rows[i]) begin
      pc_page = rows[i].page;
      dm(4'h8, 3'h0, ADDR_TBL_PTR_LOW, rows[i].lo);
      dm(4'h8, 3'h0, ADDR_TBL_PTR_HIGH, rows[i].hi);
      dm(4'h4, 3'h0, ADDR_TBL_PTR_LOW, 8'h00);
      chk(rd_v, rows[i].lo);
      dm(4'h4, 3'h0, ADDR_TBL_PTR_HIGH, 8'h00);
      chk(rd_v, rows[i].hi);
      tbl(rows[i].last, rows[i].exp, rows[i].hp);
    end
    dm(4'h8, 3'h0, ADDR_TBL_HIGH, 8'hff);
    dm(4'h4, 3'h0, ADDR_TBL_HIGH, 8'h00);
    chk(rd_v, 8'h5f);
    dm(4'h8, 3'h0, 8'h10, 8'haa);
    dm(4'h4, 3'h0, 8'h10, 8'h00);
    chk(rd_v, 8'h00);
    dm(4'h8, 3'h0, 8'h20, 8'hc3);
    dm(4'h4, 3'h0, 8'h20, 8'h00);
    chk(rd_v, 8'hc3);
    dm(4'h8, 3'h0, 8'h7f, 8'h5a);
    dm(4'h2, 3'h0, 8'h7f, 8'h00);
    dm(4'h4, 3'h0, 8'h7f, 8'h00);
    chk(rd_v, 8'h5b);
    dm(4'h1, 3'h6, 8'h7f, 8'h00);
    dm(4'h4, 3'h0, 8'h7f, 8'h00);
    chk(rd_v, 8'h1b);
    // All three sources at once while the stack is full.
    stack_full = 1'b1;
    int_enable = 3'h7;
    serial_done = 1'b1;
    timer_ovf = 1'b1;
    ext_int_n = 1'b0;
    @(negedge sys_clk);
    serial_done = 1'b0;
    timer_ovf = 1'b0;
    repeat (6) begin
      chk(pc_load_q, 12'h0);
      @(negedge sys_clk);
    end
    stack_full = 1'b0;
    wait_load(VEC_SERIAL);
    wait_load(VEC_TIMER);
    wait_load(VEC_EXT);
    // A disabled source stays pending until its enable arrives.
    ext_int_n = 1'b1;
    int_enable = 3'h0;
    timer_ovf = 1'b1;
    @(negedge sys_clk);
    timer_ovf = 1'b0;
    repeat (4) begin
      chk(pc_load_q, 12'h0);
      @(negedge sys_clk);
    end
    int_enable = 3'h2;
    wait_load(VEC_TIMER);
    // A start held into the fetch cycle is refused: one read only.
    int_enable = 3'h0;
    @(negedge sys_clk);
    tbl_req = '{1'b1, 8'h41};
    tbl_start = 1'b1;
    repeat (2) @(negedge sys_clk);
    tbl_start = 1'b0;
    chk(tbl_done_q, 12'h1);
    chk(tbl_busy_q, 12'h0);
    // A reset in mid-run must bring the core back to vector zero.
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(pc_load_q, 12'h0);
    chk(tbl_busy_q, 12'h0);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk(pc_load_q, 12'h1);
    chk(pc_addr_q, VEC_RESET);
    summarize();
  end
endmodule // vtr_core_tb_top
